/* bench/ovuf_front.sv */
// Purpose: Front end model giving processed magnitudes and the evaluation tick
// Assumes: go is a one-cycle request from the bench
// Notes: Between ticks the meas lines carry the inverse of the last sample
`timescale 1ns/1ps
module ovuf_front (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire ovuf_pkg::ovuf_meas_s meas_in,
  output logic tick,
  output ovuf_pkg::ovuf_meas_s meas
);
  ovuf_pkg::ovuf_meas_s last_reg;
  // One sample per request; frequency taken from the voltage channel
  always_ff @(posedge clk) begin
    tick <= go && !rst;
    last_reg <= go ? meas_in : last_reg;
  end
  // Stale outside a tick, so a block that samples early sees junk
  assign meas = tick ? last_reg : ~last_reg;
endmodule

/* bench/tb.sv */
// Purpose: Self-checking bench for the over voltage and under frequency block
// Assumes: ov delays 2 and 3, uf delays 2 and 1, uf1 to shed, uf2 to trip
// Notes: One row is one tick; expected outs are the packed out struct
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic [15:0] va, vb, vc, f; logic inh; logic [7:0] exp;} ovuf_row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic tick;
  logic [7:0] logic_in = 8'h00;
  ovuf_pkg::ovuf_meas_s meas_in = '0;
  ovuf_pkg::ovuf_meas_s meas;
  ovuf_pkg::ovuf_cfg_s cfg;
  ovuf_pkg::ovuf_out_s outs;
  int error_cnt = 0;
  int total_checks = 0;
  ovuf_row_s rows [11];
  ovuf_front u_front (.clk(clk), .rst(rst), .go(go), .meas_in(meas_in), .tick(tick), .meas(meas));
  ovuf_protection dut (.clk(clk), .rst(rst), .tick(tick), .meas(meas), .cfg(cfg), .logic_in(logic_in), .outs(outs));
  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request one sample; outs settle after the tick edge
  task automatic do_tick(input ovuf_row_s r);
    @(posedge clk);
    go <= 1'b1;
    meas_in <= '{r.va, r.vb, r.vc, r.f};
    logic_in <= {7'h00, r.inh};
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #20000;
    error_cnt++;
    end_sim();
  end
  initial begin
    // Nominal taken as 16'h0064: delayed stage at 100 percent with 2-tick delay, high-set at 150 percent with 3-tick delay
    cfg <= '{16'h0064, 16'h0002, 16'h0096, 16'h0003, 1'h0, 16'h01F4, 16'h0002, 16'h0190, 16'h0001,
             1'h0, 1'h1, 1'h1, 1'h0};
    rows = '{
      '{16'h0078, 16'h0078, 16'h0078, 16'h0258, 1'b0, 8'h00},
      '{16'h0078, 16'h0078, 16'h0078, 16'h0258, 1'b0, 8'h80},
      '{16'h00A0, 16'h00A0, 16'h00A0, 16'h0258, 1'b0, 8'h80},
      '{16'h00A0, 16'h00A0, 16'h00A0, 16'h01C2, 1'b0, 8'h82},
      '{16'h00A0, 16'h00A0, 16'h00A0, 16'h01C2, 1'b0, 8'hE6},
      '{16'h005A, 16'h005A, 16'h005A, 16'h015E, 1'b0, 8'h3E},
      '{16'h005A, 16'h005A, 16'h005A, 16'h015E, 1'b1, 8'h01},
      '{16'h005A, 16'h005A, 16'h005A, 16'h015E, 1'b0, 8'h1A},
      '{16'h005A, 16'h005A, 16'h005A, 16'h0258, 1'b0, 8'h00},
      '{16'h0078, 16'h0078, 16'h0064, 16'h0258, 1'b0, 8'h00},
      '{16'h0078, 16'h0078, 16'h0064, 16'h0258, 1'b0, 8'h00}};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(outs, 8'h00);
    // Ordinary rows: one tick each
    for (int i = 0; i < 11; i++) begin
      do_tick(rows[i]);
      chk(outs, rows[i].exp);
      $display("test %0d done", i);
    end
    // High-set instant acts on the first pickup tick
    @(posedge clk);
    cfg.ov_hs_instant <= 1'b1;
    do_tick('{16'h00A0, 16'h00A0, 16'h00A0, 16'h0258, 1'b0, 8'h40});
    chk(outs, 8'h40);
    $display("test instant done");
    // No tick: scrambled meas must not advance the delayed stage
    repeat (5) @(negedge clk);
    chk(outs, 8'h40);
    $display("test idle done");
    // Swapped routing: stage 1 to trip only, stage 2 to shed only
    @(posedge clk);
    cfg.uf1_to_trip <= 1'h1;
    cfg.uf1_to_shed <= 1'h0;
    cfg.uf2_to_trip <= 1'h0;
    cfg.uf2_to_shed <= 1'h1;
    do_tick('{16'h005A, 16'h005A, 16'h005A, 16'h015E, 1'h0, 8'h16});
    chk(outs, 8'h16);
    do_tick('{16'h005A, 16'h005A, 16'h005A, 16'h015E, 1'h0, 8'h3E});
    chk(outs, 8'h3E);
    $display("test routing done");
    // Reset in mid-run clears all outputs
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(outs, 8'h00);
    $display("test reset done");
    end_sim();
  end
endmodule

/* common/ovuf_pkg.sv */
// Purpose: Shared constants and carrier types for the over voltage and under frequency protection block
// Assumes: Measurements arrive already processed as magnitudes and a frequency value, refreshed per tick
// Notes: Delays are counted in evaluation ticks, not in clock cycles
package ovuf_pkg;

  localparam int VOLT_W = 16;
  localparam int FREQ_W = 16;
  localparam int DLY_W = 16;
  localparam int LOGIC_IN_W = 8;
  localparam int UF_INHIBIT_BIT = 0;
  localparam logic [DLY_W-1:0] DLY_ONE = 16'h0001;
  localparam logic [DLY_W-1:0] CNT_RST = 16'h0000;

  // Processed measurements from the front end
  typedef struct packed {
    logic [VOLT_W-1:0] v_ab;
    logic [VOLT_W-1:0] v_bc;
    logic [VOLT_W-1:0] v_ca;
    logic [FREQ_W-1:0] freq;
  } ovuf_meas_s;

  // Settings, held stable by the owner of the settings
  typedef struct packed {
    logic [VOLT_W-1:0] ov_dly_thr;
    logic [DLY_W-1:0] ov_dly_delay;
    logic [VOLT_W-1:0] ov_hs_thr;
    logic [DLY_W-1:0] ov_hs_delay;
    logic ov_hs_instant;
    logic [FREQ_W-1:0] uf_stage1_threshold;
    logic [DLY_W-1:0] uf_stage1_timer;
    logic [FREQ_W-1:0] uf_stage2_threshold;
    logic [DLY_W-1:0] uf_stage2_timer;
    logic uf1_to_trip;
    logic uf1_to_shed;
    logic uf2_to_trip;
    logic uf2_to_shed;
  } ovuf_cfg_s;

  // One stage timer
  typedef struct packed {
    logic [DLY_W-1:0] cnt;
    logic picked;
    logic fired;
  } ovuf_timer_s;

  // Whole state of the block
  typedef struct packed {
    ovuf_timer_s ov_dly;
    ovuf_timer_s ov_hs;
    ovuf_timer_s uf1;
    ovuf_timer_s uf2;
    logic uf_trip;
    logic uf_shed;
    logic uf_alarm;
    logic uv_block;
  } ovuf_state_s;

  // Outputs toward the scheme logic
  typedef struct packed {
    logic ov_dly_trip;
    logic ov_hs_trip;
    logic uf1_out;
    logic uf2_out;
    logic uf_trip;
    logic uf_shed;
    logic uf_alarm;
    logic uv_block;
  } ovuf_out_s;

endpackage

/* design/ovuf_protection.sv */
// Purpose: Two-stage over voltage and two-stage under frequency decision logic with breaker inhibit
// Assumes: tick is a one-cycle pulse from the sample scheduler; inputs are synchronous to clk
// Notes: All outputs are registered; uf1_out and uf2_out are the timed stages, cleared by the inhibit like the routed outputs
`timescale 1ns/1ps
module ovuf_protection (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire ovuf_pkg::ovuf_meas_s meas,
  input wire ovuf_pkg::ovuf_cfg_s cfg,
  input wire logic [ovuf_pkg::LOGIC_IN_W-1:0] logic_in,
  output ovuf_pkg::ovuf_out_s outs
);

  ovuf_pkg::ovuf_state_s state_reg;
  ovuf_pkg::ovuf_state_s state_next;
  logic ov_dly_pick;
  logic ov_hs_pick;
  logic uf1_pick;
  logic uf2_pick;
  logic inhibit;

  // One tick of a stage timer; a lost pickup drops it at once
  function automatic ovuf_pkg::ovuf_timer_s timer_step(
    input ovuf_pkg::ovuf_timer_s t,
    input logic pick,
    input logic [ovuf_pkg::DLY_W-1:0] dly
  );
    ovuf_pkg::ovuf_timer_s r;
    r = t;
    r.picked = pick;
    if (!pick) begin
      r.cnt = ovuf_pkg::CNT_RST;
      r.fired = 1'h0;
    end else if (t.cnt >= dly) begin
      r.fired = 1'h1;
    end else begin
      r.cnt = t.cnt + ovuf_pkg::DLY_ONE;
      r.fired = (r.cnt >= dly);
    end
    return r;
  endfunction

  // Pickup comparisons on the phase-phase magnitudes and voltage-derived frequency
  assign ov_dly_pick = (meas.v_ab > cfg.ov_dly_thr) && (meas.v_bc > cfg.ov_dly_thr) &&
                       (meas.v_ca > cfg.ov_dly_thr);
  assign ov_hs_pick = (meas.v_ab > cfg.ov_hs_thr) && (meas.v_bc > cfg.ov_hs_thr) &&
                      (meas.v_ca > cfg.ov_hs_thr);
  assign uf1_pick = meas.freq < cfg.uf_stage1_threshold;
  assign uf2_pick = meas.freq < cfg.uf_stage2_threshold;
  assign inhibit = logic_in[ovuf_pkg::UF_INHIBIT_BIT];

  // Next state; timers move only on a tick, inhibit acts every cycle
  always_comb begin
    state_next = state_reg;
    if (tick) begin
      state_next.ov_dly = timer_step(state_reg.ov_dly, ov_dly_pick, cfg.ov_dly_delay);
      if (cfg.ov_hs_instant) begin
        state_next.ov_hs.cnt = ovuf_pkg::CNT_RST;
        state_next.ov_hs.picked = ov_hs_pick;
        state_next.ov_hs.fired = ov_hs_pick;
      end else begin
        state_next.ov_hs = timer_step(state_reg.ov_hs, ov_hs_pick, cfg.ov_hs_delay);
      end
      // Separate timers, separate settings: no cross term between stages
      state_next.uf1 = timer_step(state_reg.uf1, uf1_pick, cfg.uf_stage1_timer);
      state_next.uf2 = timer_step(state_reg.uf2, uf2_pick, cfg.uf_stage2_timer);
    end
    // Clearing the timers too means no stale trip on breaker reclose
    if (inhibit) begin
      state_next.uf1 = '0;
      state_next.uf2 = '0;
    end
    state_next.uf_trip = !inhibit && ((state_next.uf1.fired && cfg.uf1_to_trip) ||
                                      (state_next.uf2.fired && cfg.uf2_to_trip));
    state_next.uf_shed = !inhibit && ((state_next.uf1.fired && cfg.uf1_to_shed) ||
                                      (state_next.uf2.fired && cfg.uf2_to_shed));
    state_next.uf_alarm = !inhibit && (state_next.uf1.picked || state_next.uf2.picked);
    state_next.uv_block = inhibit;
  end

  // State register, synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flip-flops; one driver for the whole struct
  assign outs = '{
    ov_dly_trip: state_reg.ov_dly.fired,
    ov_hs_trip: state_reg.ov_hs.fired,
    uf1_out: state_reg.uf1.fired,
    uf2_out: state_reg.uf2.fired,
    uf_trip: state_reg.uf_trip,
    uf_shed: state_reg.uf_shed,
    uf_alarm: state_reg.uf_alarm,
    uv_block: state_reg.uv_block
  };

  // Checks on the stage timing and gating
  a_dly_drop_pick: assert property (@(posedge clk) disable iff (rst)
    tick && !ov_dly_pick |=> !outs.ov_dly_trip && state_reg.ov_dly.cnt == ovuf_pkg::CNT_RST)
    else $error("delayed over voltage output kept after pickup loss");

  a_dly_all_three: assert property (@(posedge clk) disable iff (rst)
    $rose(outs.ov_dly_trip) |-> $past(tick && ov_dly_pick && state_next.ov_dly.cnt >= cfg.ov_dly_delay))
    else $error("delayed over voltage fired without all phases above threshold");

  a_hs_instant_op: assert property (@(posedge clk) disable iff (rst)
    tick && cfg.ov_hs_instant && ov_hs_pick |=> outs.ov_hs_trip)
    else $error("instant high-set did not operate on the tick");

  a_hs_timed_wait: assert property (@(posedge clk) disable iff (rst)
    $rose(outs.ov_hs_trip) && !$past(cfg.ov_hs_instant) |-> $past(state_next.ov_hs.cnt) >= $past(cfg.ov_hs_delay))
    else $error("timed high-set fired before its delay");

  a_uf_inhibit_gate: assert property (@(posedge clk) disable iff (rst)
    inhibit |=> !outs.uf_trip && !outs.uf_alarm && !outs.uf_shed && !outs.uf1_out && !outs.uf2_out)
    else $error("under frequency output while inhibited");

  a_uf1_below_thr: assert property (@(posedge clk) disable iff (rst)
    $rose(outs.uf1_out) |-> $past(tick && uf1_pick && !inhibit))
    else $error("stage 1 fired without frequency below its threshold");

  a_uf2_independent: assert property (@(posedge clk) disable iff (rst)
    tick && !inhibit && uf2_pick && !uf1_pick && state_reg.uf2.cnt < cfg.uf_stage2_timer
    |=> state_reg.uf2.cnt == $past(state_reg.uf2.cnt) + ovuf_pkg::DLY_ONE)
    else $error("stage 2 timing disturbed by stage 1");

  a_uf_route_trip: assert property (@(posedge clk) disable iff (rst)
    outs.uf_trip |-> (outs.uf1_out && $past(cfg.uf1_to_trip)) || (outs.uf2_out && $past(cfg.uf2_to_trip)))
    else $error("under frequency trip without a routed stage");

  a_hold_no_tick: assert property (@(posedge clk) disable iff (rst)
    !tick ##1 !tick |-> $stable(outs.ov_dly_trip) && $stable(state_reg.ov_dly.cnt))
    else $error("delayed over voltage timer moved between ticks");

  a_uv_block_follow: assert property (@(posedge clk) disable iff (rst)
    inhibit ##1 inhibit |-> outs.uv_block && !outs.uf_alarm)
    else $error("under voltage block not following the inhibit");

  // Delayed stage, seen per phase so a broken pickup term does not hide itself
  a_dly_low_phase: assert property (@(posedge clk) disable iff (rst)
    tick && (meas.v_ab <= cfg.ov_dly_thr || meas.v_bc <= cfg.ov_dly_thr || meas.v_ca <= cfg.ov_dly_thr)
    |=> !outs.ov_dly_trip && state_reg.ov_dly.cnt == ovuf_pkg::CNT_RST)
    else $error("delayed over voltage kept with one phase at or below threshold");

  a_dly_cnt_step: assert property (@(posedge clk) disable iff (rst)
    tick && ov_dly_pick && state_reg.ov_dly.cnt < cfg.ov_dly_delay
    |=> state_reg.ov_dly.cnt == $past(state_reg.ov_dly.cnt) + ovuf_pkg::DLY_ONE)
    else $error("delayed over voltage count did not step on a pickup tick");

  a_dly_cnt_sat: assert property (@(posedge clk) disable iff (rst)
    tick && ov_dly_pick && state_reg.ov_dly.cnt >= cfg.ov_dly_delay
    |=> outs.ov_dly_trip && $stable(state_reg.ov_dly.cnt))
    else $error("delayed over voltage count moved past its delay");

  a_dly_fire_end: assert property (@(posedge clk) disable iff (rst)
    tick && ov_dly_pick && (state_reg.ov_dly.cnt + ovuf_pkg::DLY_ONE >= cfg.ov_dly_delay)
    |=> outs.ov_dly_trip)
    else $error("delayed over voltage did not fire when its delay ran out");

  a_dly_no_early: assert property (@(posedge clk) disable iff (rst)
    tick && ov_dly_pick && state_reg.ov_dly.cnt < cfg.ov_dly_delay &&
    (state_reg.ov_dly.cnt + ovuf_pkg::DLY_ONE < cfg.ov_dly_delay) |=> !outs.ov_dly_trip)
    else $error("delayed over voltage fired before its delay");

  // High-set stage in both modes; a mode change between ticks must not leave a stale count
  a_hs_low_phase: assert property (@(posedge clk) disable iff (rst)
    tick && (meas.v_ab <= cfg.ov_hs_thr || meas.v_bc <= cfg.ov_hs_thr || meas.v_ca <= cfg.ov_hs_thr)
    |=> !outs.ov_hs_trip)
    else $error("high-set kept with one phase at or below threshold");

  a_hs_instant_cnt: assert property (@(posedge clk) disable iff (rst)
    tick && cfg.ov_hs_instant
    |=> state_reg.ov_hs.cnt == ovuf_pkg::CNT_RST)
    else $error("instant high-set left its count running");

  a_hs_instant_drop: assert property (@(posedge clk) disable iff (rst)
    tick && cfg.ov_hs_instant && !ov_hs_pick
    |=> !outs.ov_hs_trip)
    else $error("instant high-set held without pickup");

  a_hs_cnt_step: assert property (@(posedge clk) disable iff (rst)
    tick && !cfg.ov_hs_instant && ov_hs_pick && state_reg.ov_hs.cnt < cfg.ov_hs_delay
    |=> state_reg.ov_hs.cnt == $past(state_reg.ov_hs.cnt) + ovuf_pkg::DLY_ONE)
    else $error("timed high-set count did not step on a pickup tick");

  a_hs_no_early: assert property (@(posedge clk) disable iff (rst)
    tick && !cfg.ov_hs_instant && ov_hs_pick && state_reg.ov_hs.cnt < cfg.ov_hs_delay &&
    (state_reg.ov_hs.cnt + ovuf_pkg::DLY_ONE < cfg.ov_hs_delay) |=> !outs.ov_hs_trip)
    else $error("timed high-set fired before its own delay");

  a_hs_fire_end: assert property (@(posedge clk) disable iff (rst)
    tick && !cfg.ov_hs_instant && ov_hs_pick && (state_reg.ov_hs.cnt + ovuf_pkg::DLY_ONE >= cfg.ov_hs_delay)
    |=> outs.ov_hs_trip)
    else $error("timed high-set did not fire when its delay ran out");

  a_hs_timed_drop: assert property (@(posedge clk) disable iff (rst)
    tick && !cfg.ov_hs_instant && !ov_hs_pick
    |=> !outs.ov_hs_trip && state_reg.ov_hs.cnt == ovuf_pkg::CNT_RST)
    else $error("timed high-set kept its count after pickup loss");

  a_hs_hold_idle: assert property (@(posedge clk) disable iff (rst)
    !tick
    |=> state_reg.ov_hs == $past(state_reg.ov_hs))
    else $error("high-set stage moved between ticks");

  // Under frequency timing, each stage against its own threshold and delay
  a_uf1_freq_high: assert property (@(posedge clk) disable iff (rst)
    tick && meas.freq >= cfg.uf_stage1_threshold
    |=> !outs.uf1_out && state_reg.uf1.cnt == ovuf_pkg::CNT_RST)
    else $error("stage 1 kept timing at or above its threshold");

  a_uf2_freq_high: assert property (@(posedge clk) disable iff (rst)
    tick && meas.freq >= cfg.uf_stage2_threshold
    |=> !outs.uf2_out && state_reg.uf2.cnt == ovuf_pkg::CNT_RST)
    else $error("stage 2 kept timing at or above its threshold");

  a_uf2_below_thr: assert property (@(posedge clk) disable iff (rst)
    $rose(outs.uf2_out)
    |-> $past(tick && uf2_pick && !inhibit))
    else $error("stage 2 fired without frequency below its threshold");

  a_uf1_independent: assert property (@(posedge clk) disable iff (rst)
    tick && !inhibit && uf1_pick && !uf2_pick && state_reg.uf1.cnt < cfg.uf_stage1_timer
    |=> state_reg.uf1.cnt == $past(state_reg.uf1.cnt) + ovuf_pkg::DLY_ONE)
    else $error("stage 1 timing disturbed by stage 2");

  a_uf1_fire_end: assert property (@(posedge clk) disable iff (rst)
    tick && !inhibit && uf1_pick && (state_reg.uf1.cnt + ovuf_pkg::DLY_ONE >= cfg.uf_stage1_timer)
    |=> outs.uf1_out)
    else $error("stage 1 did not fire when its delay ran out");

  a_uf2_fire_end: assert property (@(posedge clk) disable iff (rst)
    tick && !inhibit && uf2_pick && (state_reg.uf2.cnt + ovuf_pkg::DLY_ONE >= cfg.uf_stage2_timer)
    |=> outs.uf2_out)
    else $error("stage 2 did not fire when its delay ran out");

  a_uf1_no_early: assert property (@(posedge clk) disable iff (rst)
    tick && uf1_pick && state_reg.uf1.cnt < cfg.uf_stage1_timer &&
    (state_reg.uf1.cnt + ovuf_pkg::DLY_ONE < cfg.uf_stage1_timer) |=> !outs.uf1_out)
    else $error("stage 1 fired before its delay");

  a_uf2_no_early: assert property (@(posedge clk) disable iff (rst)
    tick && uf2_pick && state_reg.uf2.cnt < cfg.uf_stage2_timer &&
    (state_reg.uf2.cnt + ovuf_pkg::DLY_ONE < cfg.uf_stage2_timer) |=> !outs.uf2_out)
    else $error("stage 2 fired before its delay");

  a_uf_hold_idle: assert property (@(posedge clk) disable iff (rst)
    !tick && !inhibit
    |=> state_reg.uf1 == $past(state_reg.uf1) && state_reg.uf2 == $past(state_reg.uf2))
    else $error("under frequency stages moved between ticks");

  // Routing and inhibit; the last two checks look at the inhibit bit directly, not through its wire
  a_uf_inhibit_clear: assert property (@(posedge clk) disable iff (rst)
    inhibit
    |=> state_reg.uf1.cnt == ovuf_pkg::CNT_RST && state_reg.uf2.cnt == ovuf_pkg::CNT_RST)
    else $error("under frequency timers kept counts while inhibited");

  a_uf_route_shed: assert property (@(posedge clk) disable iff (rst)
    outs.uf_shed
    |-> (outs.uf1_out && $past(cfg.uf1_to_shed)) || (outs.uf2_out && $past(cfg.uf2_to_shed)))
    else $error("load shedding without a routed stage");

  a_uf_trip_made: assert property (@(posedge clk) disable iff (rst)
    (outs.uf1_out && $past(cfg.uf1_to_trip)) || (outs.uf2_out && $past(cfg.uf2_to_trip))
    |-> outs.uf_trip)
    else $error("routed stage did not give an under frequency trip");

  a_uf_shed_made: assert property (@(posedge clk) disable iff (rst)
    (outs.uf1_out && $past(cfg.uf1_to_shed)) || (outs.uf2_out && $past(cfg.uf2_to_shed))
    |-> outs.uf_shed)
    else $error("routed stage did not give load shedding");

  a_uf_alarm_pick: assert property (@(posedge clk) disable iff (rst)
    tick && !inhibit && (uf1_pick || uf2_pick)
    |=> outs.uf_alarm)
    else $error("under frequency alarm missing on a pickup tick");

  a_uf_alarm_none: assert property (@(posedge clk) disable iff (rst)
    tick && !uf1_pick && !uf2_pick
    |=> !outs.uf_alarm)
    else $error("under frequency alarm without a pickup");

  a_inh_bit_set: assert property (@(posedge clk) disable iff (rst)
    logic_in[ovuf_pkg::UF_INHIBIT_BIT]
    |=> outs.uv_block && !outs.uf_trip)
    else $error("inhibit input bit not acting as the inhibit");

  a_inh_bit_clear: assert property (@(posedge clk) disable iff (rst)
    !logic_in[ovuf_pkg::UF_INHIBIT_BIT]
    |=> !outs.uv_block)
    else $error("under voltage block held without the inhibit bit");

  c_dly_trip: cover property (@(posedge clk) disable iff (rst) $rose(outs.ov_dly_trip));
  c_hs_instant: cover property (@(posedge clk) disable iff (rst) $rose(outs.ov_hs_trip) && cfg.ov_hs_instant);
  c_uf_shed: cover property (@(posedge clk) disable iff (rst) $rose(outs.uf_shed));
  c_uf_inhibited: cover property (@(posedge clk) disable iff (rst) uf1_pick && tick && inhibit);
  c_uf_trip: cover property (@(posedge clk) disable iff (rst) $rose(outs.uf_trip) && outs.uf1_out);

endmodule
